// *** logic/udi_pkg.sv ***
// constants and register map for the usb device interrupt logic
// Behaviour
// - each usb event sets its own sticky bit; per-source enable gates it
// - global allow bit in mode register masks the level output and pulse starts; a pulse already running completes
// - two config bits select output polarity and level or pulse signalling
// - after reset the output is active low and in level signalling
// - pulse signalling emits one 200 ns (4 cycle) pulse on each zero-to-one of the OR while no pulse runs
// - status read clears bus reset, resume, dma done and frame bits
// - endpoint bits clear only on a read of their own endpoint register
// - bus state bit is live, never latched, and reads the present state
// - setup and out endpoint events come only after the data was acknowledged
// - bulk endpoints raise an event on every ack for out or in
// - isochronous endpoints raise an event on every completed packet
// - pseudo frame interrupt has its own bit in the enable register
// - a missing frame start makes a pseudo frame tick every 1 ms; ticks stop at the third miss, when suspend is entered
// - three missed frame starts in a row enter the suspend state
// - bits 23..10 endpoints 14..1, 9 ctrl in, 8 ctrl out, 5..0 events
// - status bit 7 gives bus state: zero awake, one suspended
// - dma done bit sets when the dma transfer counter reaches zero
package udi_pkg;

    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_MODE    = 8'h08;
    localparam logic [7:0] OFS_HWCFG   = 8'h0C;
    localparam logic [7:0] OFS_ISO_SEL = 8'h10;
    localparam logic [7:0] OFS_EP_BASE = 8'h40;
    localparam logic [7:0] OFS_EP_LAST = 8'h7C;

    localparam int BIT_BUS_RESET  = 0;
    localparam int BIT_RESUME     = 1;
    localparam int BIT_SLEEP_CHG  = 2;
    localparam int BIT_DMA_DONE   = 3;
    localparam int BIT_FRAME      = 4;
    localparam int BIT_PSEUDO     = 5;
    localparam int BIT_BUS_STATE  = 7;
    localparam int BIT_EP_FIRST   = 8;
    localparam int NUM_EP         = 16;

    localparam int BIT_MODE_ALLOW = 0;
    localparam int BIT_CFG_POL    = 0;
    localparam int BIT_CFG_PULSE  = 1;

    // bits that hold a sticky flag; 6 reserved, 7 live
    localparam logic [23:0] LATCH_MASK   = 24'hFFFF3F;
    localparam logic [23:0] READ_CLR     = 24'h00001B;
    localparam logic [23:0] WRITE_CLR    = 24'h000024;
    localparam logic [15:0] ISO_ALLOWED  = 16'hFFFC;

    localparam logic [23:0] RST_ENABLE   = 24'h000000;
    localparam logic        RST_ALLOW    = 1'b0;
    localparam logic        RST_POL      = 1'b0;
    localparam logic        RST_PULSE    = 1'b0;

    localparam int CLK_MHZ        = 20;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int PULSE_NS       = 166;
    localparam int PULSE_CYC      = (PULSE_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int FRAME_US       = 1000;
    localparam int FRAME_CYC      = FRAME_US * CLK_MHZ;
    localparam int MISS_LIMIT     = 3;

endpackage

// *** logic/udi_sync.sv ***
// two flop synchroniser for level inputs
`timescale 1ns/10ps
module udi_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } udi_sync_t;

    udi_sync_t st_reg;
    udi_sync_t st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.first  = din;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.second;
endmodule

// *** logic/udi_irq_top.sv ***
// usb device interrupt logic with apb register slave
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module udi_irq_top #(
    parameter int FRAME_CYCLES = udi_pkg::FRAME_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_reset_evt,
    input  wire logic        resume_evt,
    input  wire logic        sof_evt,
    input  wire logic        dma_count_done,
    input  wire logic [15:0] ep_ack_out,
    input  wire logic [15:0] ep_ack_in,
    input  wire logic [15:0] ep_iso_done,
    input  wire logic        bus_sleep_state,
    output logic             irq_out,
    output logic             auto_sleep
);
    typedef struct packed {
        logic [23:0] status;
        logic [23:0] enable;
        logic        global_irq_allow;
        logic        irq_polarity_sel;
        logic        irq_signalling_sel;
        logic [15:0] iso_sel;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        any_q;
        logic [2:0]  pulse_cnt;
        logic        irq;
        logic [15:0] frame_cnt;
        logic        frame_run;
        logic [1:0]  miss;
        logic        auto_sleep;
        logic        sleep_q;
    } udi_state_t;

    localparam logic [2:0]  PULSE_LOAD = 3'(udi_pkg::PULSE_CYC);
    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
    localparam logic [1:0]  MISS_LAST  = 2'(udi_pkg::MISS_LIMIT - 1);

    udi_state_t st_reg;
    udi_state_t st_next;
    logic       sleep_sync;
    logic [15:0] ep_evt;
    logic [23:0] status_view;
    logic        setup_ph;
    logic        access_ph;
    logic        any_en;
    logic        irq_act;

    // bus state comes straight from the transceiver, outside our clock
    udi_sync #(
        .W (1)
    ) u_sleep_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (bus_sleep_state),
        .dout    (sleep_sync)
    );

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;

    // ack pulses arrive from the serial engine only after the handshake
    always_comb begin
        for (int i = 0; i < udi_pkg::NUM_EP; i++) begin
            ep_evt[i] = st_reg.iso_sel[i] ? ep_iso_done[i]
                      : (ep_ack_out[i] || ep_ack_in[i]);
        end
    end

    always_comb begin
        status_view = st_reg.status & udi_pkg::LATCH_MASK;
        status_view[udi_pkg::BIT_BUS_STATE] = sleep_sync;
    end

    // the enable bit 5 is the pseudo frame allow, same layout as status
    assign any_en = st_reg.global_irq_allow
                 && |(st_reg.status & udi_pkg::LATCH_MASK
                      & st_reg.enable);

    always_comb begin
        logic [23:0] set_v;
        logic [23:0] clr_v;
        logic [7:0]  a;
        logic        mapped;
        logic        active;
        int          ep_idx;
        set_v  = '0;
        clr_v  = '0;
        a      = paddr;
        mapped = 1'b0;
        active = 1'b0;
        ep_idx = 0;
        st_next       = st_reg;
        st_next.ready = 1'b1;

        // event sources, laid out as the status word
        set_v[udi_pkg::BIT_BUS_RESET] = bus_reset_evt;
        set_v[udi_pkg::BIT_RESUME]    = resume_evt;
        set_v[udi_pkg::BIT_DMA_DONE]  = dma_count_done;
        set_v[udi_pkg::BIT_FRAME]     = sof_evt;
        set_v[udi_pkg::BIT_SLEEP_CHG] = sleep_sync && !st_reg.sleep_q;
        set_v[23:udi_pkg::BIT_EP_FIRST] = ep_evt;
        st_next.sleep_q = sleep_sync;

        // pseudo frame timer runs only once frames have been seen
        if (bus_reset_evt) begin
            st_next.frame_run  = 1'b0;
            st_next.frame_cnt  = '0;
            st_next.miss       = '0;
            st_next.auto_sleep = 1'b0;
        end else if (sof_evt) begin
            st_next.frame_run  = 1'b1;
            st_next.frame_cnt  = '0;
            st_next.miss       = '0;
            st_next.auto_sleep = 1'b0;
        end else if (st_reg.frame_run) begin
            if (st_reg.frame_cnt == FRAME_LAST) begin
                st_next.frame_cnt = '0;
                set_v[udi_pkg::BIT_PSEUDO] = 1'b1;
                if (st_reg.miss == MISS_LAST) begin
                    st_next.auto_sleep = 1'b1;
                    st_next.frame_run  = 1'b0;
                    st_next.miss       = '0;
                end else begin
                    st_next.miss = st_reg.miss + 2'h1;
                end
            end else begin
                st_next.frame_cnt = st_reg.frame_cnt + 16'h0001;
            end
        end
        if (resume_evt) begin
            st_next.auto_sleep = 1'b0;
        end

        // apb decode; read data is caught in setup so access clears only
        // bits that were actually reported, so no event slips through
        if (a == udi_pkg::OFS_STATUS || a == udi_pkg::OFS_ENABLE
            || a == udi_pkg::OFS_MODE || a == udi_pkg::OFS_HWCFG
            || a == udi_pkg::OFS_ISO_SEL) begin
            mapped = 1'b1;
        end
        if (a >= udi_pkg::OFS_EP_BASE && a <= udi_pkg::OFS_EP_LAST
            && a[1:0] == 2'b00) begin
            mapped = 1'b1;
            ep_idx = int'(a[5:2]);
        end

        if (setup_ph) begin
            st_next.slverr = !mapped;
            st_next.rdata  = '0;
            if (!pwrite) begin
                if (a == udi_pkg::OFS_STATUS) begin
                    st_next.rdata = {8'h00, status_view};
                end else if (a == udi_pkg::OFS_ENABLE) begin
                    st_next.rdata = {8'h00, st_reg.enable};
                end else if (a == udi_pkg::OFS_MODE) begin
                    st_next.rdata[udi_pkg::BIT_MODE_ALLOW] =
                        st_reg.global_irq_allow;
                end else if (a == udi_pkg::OFS_HWCFG) begin
                    st_next.rdata[udi_pkg::BIT_CFG_POL] =
                        st_reg.irq_polarity_sel;
                    st_next.rdata[udi_pkg::BIT_CFG_PULSE] =
                        st_reg.irq_signalling_sel;
                end else if (a == udi_pkg::OFS_ISO_SEL) begin
                    st_next.rdata = {16'h0000, st_reg.iso_sel};
                end else if (mapped) begin
                    st_next.rdata[0] =
                        st_reg.status[udi_pkg::BIT_EP_FIRST + ep_idx];
                end
            end
        end

        if (access_ph && !pwrite && a == udi_pkg::OFS_STATUS) begin
            clr_v = st_reg.rdata[23:0] & udi_pkg::READ_CLR;
        end
        if (access_ph && !pwrite && mapped
            && a >= udi_pkg::OFS_EP_BASE) begin
            clr_v[udi_pkg::BIT_EP_FIRST + ep_idx] =
                st_reg.rdata[0];
        end
        if (access_ph && pwrite) begin
            unique case (a)
                udi_pkg::OFS_STATUS: begin
                    clr_v = pwdata[23:0] & udi_pkg::WRITE_CLR;
                end
                udi_pkg::OFS_ENABLE: begin
                    st_next.enable = pwdata[23:0] & udi_pkg::LATCH_MASK;
                end
                udi_pkg::OFS_MODE: begin
                    st_next.global_irq_allow = pwdata[udi_pkg::BIT_MODE_ALLOW];
                end
                udi_pkg::OFS_HWCFG: begin
                    st_next.irq_polarity_sel   = pwdata[udi_pkg::BIT_CFG_POL];
                    st_next.irq_signalling_sel =
                        pwdata[udi_pkg::BIT_CFG_PULSE];
                end
                udi_pkg::OFS_ISO_SEL: begin
                    st_next.iso_sel = pwdata[15:0] & udi_pkg::ISO_ALLOWED;
                end
                default: begin
                end
            endcase
        end

        // a set in the same cycle as its clear wins
        st_next.status = ((st_reg.status & ~clr_v) | set_v)
                       & udi_pkg::LATCH_MASK;

        // output stage; pulse retrigger is ignored while a pulse runs
        st_next.any_q = any_en;
        if (st_reg.pulse_cnt != 3'h0) begin
            st_next.pulse_cnt = st_reg.pulse_cnt - 3'h1;
        end else if (any_en && !st_reg.any_q
                     && st_reg.irq_signalling_sel) begin
            st_next.pulse_cnt = PULSE_LOAD;
        end
        active = st_reg.irq_signalling_sel ? (st_next.pulse_cnt != 3'h0)
                                           : any_en;
        st_next.irq = st_reg.irq_polarity_sel ? active : !active;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg                    <= '0;
            st_reg.enable             <= udi_pkg::RST_ENABLE;
            st_reg.global_irq_allow   <= udi_pkg::RST_ALLOW;
            st_reg.irq_polarity_sel   <= udi_pkg::RST_POL;
            st_reg.irq_signalling_sel <= udi_pkg::RST_PULSE;
            st_reg.irq                <= ~udi_pkg::RST_POL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata     = st_reg.rdata;
    assign pready     = st_reg.ready;
    assign pslverr    = st_reg.slverr;
    assign irq_out    = st_reg.irq;
    assign auto_sleep = st_reg.auto_sleep;
    assign irq_act    = st_reg.irq_polarity_sel ? irq_out : !irq_out;

    // checks
    evt_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_reset_evt |=> st_reg.status[0])
        else $error("bus reset event not latched");
    global_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_reg.global_irq_allow && !st_reg.irq_signalling_sel)
        |=> !irq_act)
        else $error("irq active while globally masked");
    level_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_reg.irq_signalling_sel && any_en)
        |=> irq_out == $past(st_reg.irq_polarity_sel))
        else $error("level irq wrong polarity");
    reset_dflt_a: assert property (@(posedge pclk)
        !presetn |-> (irq_out && !st_reg.irq_polarity_sel
                      && !st_reg.irq_signalling_sel))
        else $error("irq defaults wrong in reset");
    pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(irq_act) && st_reg.irq_signalling_sel
         && $stable(st_reg.irq_polarity_sel))
        |-> irq_act[*4] ##1 !irq_act)
        else $error("irq pulse not four cycles");
    read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && !pwrite && paddr == udi_pkg::OFS_STATUS
         && st_reg.rdata[0] && !bus_reset_evt)
        |=> !st_reg.status[0])
        else $error("bus reset bit not cleared by read");
    ep_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && paddr == udi_pkg::OFS_STATUS && st_reg.status[8])
        |=> st_reg.status[8])
        else $error("endpoint bit cleared by status read");
    bus_live_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr == udi_pkg::OFS_STATUS)
        |=> st_reg.rdata[7] == $past(sleep_sync))
        else $error("bus state bit not live");
    bulk_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_reg.iso_sel[2] && ep_ack_in[2])
        |=> st_reg.status[10])
        else $error("bulk ack not latched");
    iso_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.iso_sel[2] && ep_iso_done[2])
        |=> st_reg.status[10])
        else $error("iso packet not latched");
    pseudo_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.frame_run && st_reg.frame_cnt == FRAME_LAST
         && !sof_evt && !bus_reset_evt) |=> st_reg.status[5])
        else $error("pseudo frame tick missing");
    miss_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.frame_run && st_reg.frame_cnt == FRAME_LAST
         && st_reg.miss == 2'h2 && !sof_evt && !bus_reset_evt
         && !resume_evt) |=> auto_sleep)
        else $error("no suspend after three misses");
    dma_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        dma_count_done |=> st_reg.status[3])
        else $error("dma done not latched");

    pulse_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_reg.irq_signalling_sel && $rose(irq_act));
    auto_sleep_c: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(auto_sleep));
    ep_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(st_reg.status[10]));
endmodule

// *** tb/udi_fw_model.sv ***
// firmware side model: watches the interrupt pin and times each assertion
`timescale 1ns/10ps
module udi_fw_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic irq_out,
    input  wire logic pol_high,
    output logic      active,
    output int        last_len
);
    int run;
    // compared with ===, so an unknown pin never counts as asserted
    assign active = (irq_out === pol_high);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 0;
            last_len <= 0;
        end else if (active) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_len <= run;
            run <= 0;
        end
    end
endmodule

// *** tb/usb_device_interrupt_logic_bench.sv ***
// self-checking bench for the usb device interrupt logic
`timescale 1ns/10ps
module usb_device_interrupt_logic_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  evt = 4'h0;
    logic [15:0] ack_o = 16'h0;
    logic [15:0] ack_i = 16'h0;
    logic [15:0] iso_d = 16'h0;
    logic        sleep_in = 1'b0;
    logic        irq_out;
    logic        auto_sleep;
    logic        pol_high = 1'b0;
    logic        fw_active;
    int          pulse_len;
    int          failures = 0;
    int          checks = 0;

    initial forever #25 pclk = ~pclk;

    // short frame so three missed frame starts fit in a few hundred cycles
    udi_irq_top #(.FRAME_CYCLES(50)) u_udi_irq_top (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_reset_evt(evt[0]),
        .resume_evt(evt[1]), .sof_evt(evt[2]),
        .dma_count_done(evt[3]), .ep_ack_out(ack_o),
        .ep_ack_in(ack_i), .ep_iso_done(iso_d),
        .bus_sleep_state(sleep_in), .irq_out(irq_out),
        .auto_sleep(auto_sleep));

    udi_fw_model u_udi_fw_model (
        .pclk(pclk), .presetn(presetn), .irq_out(irq_out),
        .pol_high(pol_high), .active(fw_active), .last_len(pulse_len));

    task automatic conclude();
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask

    // whole 32-bit word in one transfer, as firmware must
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] x);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
        chk({nm, "_err"}, 32'h0, {31'h0, e});
    endtask

    task automatic fire(input logic [3:0] s, input logic [15:0] o,
                        input logic [15:0] i, input logic [15:0] d);
        @(posedge pclk);
        evt <= s;
        ack_o <= o;
        ack_i <= i;
        iso_d <= d;
        @(posedge pclk);
        evt <= 4'h0;
        ack_o <= 16'h0;
        ack_i <= 16'h0;
        iso_d <= 16'h0;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        logic e;
        // a real falling edge, so the flops are reset before the first clock
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("irq_in_reset", 32'h1, {31'h0, irq_out});
        presetn <= 1'b1;
        rdc("hwcfg_rst", udi_pkg::OFS_HWCFG, 32'h0);
        rdc("enable_rst", udi_pkg::OFS_ENABLE, 32'h0);
        wr(udi_pkg::OFS_ENABLE, 32'h00FFFF3F);
        fire(4'b1011, 16'h0, 16'h0, 16'h0);
        wait_clk(3);
        chk("irq_masked", 32'h1, {31'h0, irq_out});
        wr(udi_pkg::OFS_MODE, 32'h1);
        wait_clk(3);
        chk("irq_level", 32'h0, {31'h0, irq_out});
        rdc("stat_evt", udi_pkg::OFS_STATUS,
            32'h0000000B);
        rdc("stat_clr", udi_pkg::OFS_STATUS, 32'h0);
        wait_clk(3);
        chk("irq_idle", 32'h1, {31'h0, irq_out});
        wr(udi_pkg::OFS_ENABLE, 32'h00000001);
        fire(4'b0010, 16'h0, 16'h0, 16'h0);
        wait_clk(3);
        chk("irq_src_off", 32'h1, {31'h0, irq_out});
        rdc("stat_res", udi_pkg::OFS_STATUS, 32'h00000002);
        wr(udi_pkg::OFS_ENABLE, 32'h00FFFF3F);
        // active high pulse mode
        wr(udi_pkg::OFS_HWCFG, 32'h3);
        pol_high <= 1'b1;
        wait_clk(3);
        chk("irq_pol", 32'h0, {31'h0, irq_out});
        fire(4'b0010, 16'h0, 16'h0, 16'h0);
        wait_clk(10);
        chk("pulse_len", 32'h4, pulse_len);
        chk("pulse_end", 32'h0, {31'h0, irq_out});
        rdc("stat_pls", udi_pkg::OFS_STATUS, 32'h00000002);
        wr(udi_pkg::OFS_HWCFG, 32'h0);
        pol_high <= 1'b0;
        fire(4'b0000, 16'h0001, 16'h0004, 16'h0);
        rdc("stat_ep", udi_pkg::OFS_STATUS,
            32'h00000500);
        rdc("stat_ep2", udi_pkg::OFS_STATUS, 32'h00000500);
        rdc("ep0_out", 8'h40, 32'h1);
        rdc("ep1", 8'h48, 32'h1);
        rdc("stat_ep3", udi_pkg::OFS_STATUS, 32'h0);
        wr(udi_pkg::OFS_ISO_SEL, 32'h4);
        fire(4'b0000, 16'h0004, 16'h0, 16'h0);
        rdc("iso_ack", udi_pkg::OFS_STATUS, 32'h0);
        fire(4'b0000, 16'h0, 16'h0, 16'h0004);
        rdc("iso_done", udi_pkg::OFS_STATUS, 32'h00000400);
        rdc("iso_ep", 8'h48, 32'h1);
        sleep_in <= 1'b1;
        wait_clk(4);
        rdc("bus_sleep", udi_pkg::OFS_STATUS,
            32'h00000084);
        wr(udi_pkg::OFS_STATUS, 32'h4);
        rdc("bus_live", udi_pkg::OFS_STATUS, 32'h00000080);
        sleep_in <= 1'b0;
        wait_clk(4);
        rdc("bus_awake", udi_pkg::OFS_STATUS, 32'h0);
        xfer(1'b0, 8'h20, 32'h0, r, e);
        chk("unmap_data", 32'h0, r);
        chk("unmap_err", 32'h1, {31'h0, e});
        // iso handled by frame ticks alone; endpoint irqs stay off
        wr(udi_pkg::OFS_ENABLE, 32'h00000030);
        // frame start, then let it go missing
        fire(4'b0100, 16'h0, 16'h0, 16'h0);
        rdc("stat_sof", udi_pkg::OFS_STATUS, 32'h00000010);
        rdc("sof_clr", udi_pkg::OFS_STATUS, 32'h0);
        wait_clk(55);
        rdc("synthetic_frame_tick_1", udi_pkg::OFS_STATUS, 32'h00000020);
        chk("irq_synthetic_frame_tick", 32'h0, {31'h0, irq_out});
        wr(udi_pkg::OFS_STATUS, 32'h20);
        rdc("synthetic_frame_tick_clr", udi_pkg::OFS_STATUS, 32'h0);
        wait_clk(45);
        rdc("synthetic_frame_tick_2", udi_pkg::OFS_STATUS, 32'h00000020);
        chk("awake_2", 32'h0, {31'h0, auto_sleep});
        wait_clk(45);
        chk("sleep_3", 32'h1, {31'h0, auto_sleep});
        fire(4'b0100, 16'h0, 16'h0, 16'h0);
        wait_clk(3);
        chk("sof_wake", 32'h0, {31'h0, auto_sleep});
        conclude();
    end
endmodule
